/* File: hw/ccd_pkg.sv */
package ccd_pkg;

    // ------------------------------------------------------------
    // Widths and sizes
    // ------------------------------------------------------------
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned ADDR_W     = 6;
    localparam int unsigned FILE_DEPTH = 64;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] WORKING_RST    = 8'h00;
    localparam logic       ZERO_FLAG_RST  = 1'b0;
    localparam logic       CARRY_FLAG_RST = 1'b0;
    localparam logic       HALF_FLAG_RST  = 1'b0;
    localparam logic       EXPIRY_RST     = 1'b1;
    localparam logic       SLEEP_RST      = 1'b1;

    // ------------------------------------------------------------
    // Data constants
    // ------------------------------------------------------------
    localparam logic [7:0] ZERO_BYTE      = 8'h00;
    localparam logic [7:0] ONE_BYTE       = 8'h01;
    localparam logic [3:0] DIGIT_MAX      = 4'h9;
    localparam logic [7:0] PAIR_MAX       = 8'h99;
    localparam logic [7:0] LOW_FIX        = 8'h06;
    localparam logic [7:0] HIGH_FIX       = 8'h60;

    // ------------------------------------------------------------
    // Destination selector
    // ------------------------------------------------------------
    localparam logic       DEST_WORKING   = 1'b0;
    localparam logic       DEST_FILE      = 1'b1;

    // ------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CCD_OP_NONE,
        CCD_OP_ZERO_WORKING,
        CCD_OP_ZERO_REGISTER,
        CCD_OP_INVERT_REGISTER,
        CCD_OP_MINUS_ONE_REGISTER,
        CCD_OP_WATCHDOG_KICK,
        CCD_OP_COMPARE_WITH_REGISTER,
        CCD_OP_DECIMAL_ADJUST
    } ccd_op_t;

endpackage

/* File: hw/ccd_datapath.sv */
`timescale 1ns/100ps
module ccd_datapath #(
    parameter int unsigned DATA_W     = ccd_pkg::DATA_W,
    parameter int unsigned ADDR_W     = ccd_pkg::ADDR_W,
    parameter int unsigned FILE_DEPTH = ccd_pkg::FILE_DEPTH
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // Operation issue
    input  wire logic              op_valid,
    input  wire logic [2:0]        op_code,
    input  wire logic [ADDR_W-1:0] op_addr,
    input  wire logic              op_dest,
    output logic                   op_done,
    // Result of the preceding addition
    input  wire logic              sum_load,
    input  wire logic [DATA_W-1:0] sum_value,
    input  wire logic              sum_carry,
    input  wire logic              sum_half_carry,
    // Outside file writes and reads
    input  wire logic              ext_we,
    input  wire logic [ADDR_W-1:0] ext_addr,
    input  wire logic [DATA_W-1:0] ext_wdata,
    input  wire logic [ADDR_W-1:0] peek_addr,
    output logic      [DATA_W-1:0] peek_data,
    // Watchdog side
    input  wire logic              divider_to_watchdog,
    input  wire logic              watchdog_timeout_evt,
    input  wire logic              sleep_evt,
    output logic                   watchdog_counter_clear,
    output logic                   watchdog_divider_clear,
    // State
    output logic      [DATA_W-1:0] working_register,
    output logic                   result_null_flag,
    output logic                   borrow_not_flag,
    output logic                   half_carry_flag,
    output logic                   watchdog_expiry_flag,
    output logic                   sleep_entered_flag
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Decimal adjust and the byte constants only make sense for 8 bits
    if (DATA_W != 8) begin : g_bad_width
        $error("ccd_datapath: DATA_W must be 8");
    end
    if (FILE_DEPTH > (1 << ADDR_W) || FILE_DEPTH == 0) begin : g_bad_depth
        $error("ccd_datapath: FILE_DEPTH does not fit ADDR_W");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [DATA_W-1:0] file_q [FILE_DEPTH];
    logic [DATA_W-1:0] working_q;
    logic [DATA_W-1:0] working_d;
    logic              zero_q;
    logic              zero_d;
    logic              carry_q;
    logic              carry_d;
    logic              half_q;
    logic              half_d;
    logic              expiry_q;
    logic              expiry_d;
    logic              sleep_q;
    logic              sleep_d;
    logic              done_q;
    logic              done_d;
    logic              wdt_clr_q;
    logic              wdt_clr_d;
    logic              div_clr_q;
    logic              div_clr_d;
    logic [DATA_W-1:0] peek_q;
    logic [DATA_W-1:0] peek_d;

    logic              file_we;
    logic [ADDR_W-1:0] file_addr;
    logic [DATA_W-1:0] file_wdata;

    ccd_pkg::ccd_op_t  op;
    logic [DATA_W-1:0] src;
    logic [DATA_W-1:0] result;
    logic [DATA_W:0]   diff;
    logic [DATA_W-1:0] adjusted;
    logic              adj_carry;

    assign op  = op_valid ? ccd_pkg::ccd_op_t'(op_code) : ccd_pkg::CCD_OP_NONE;
    // Addresses beyond the implemented depth read as zero
    assign src = (32'(op_addr) < FILE_DEPTH) ? file_q[op_addr] : ccd_pkg::ZERO_BYTE;

    // ------------------------------------------------------------
    // Arithmetic
    // ------------------------------------------------------------
    always_comb begin
        // Extra bit of the difference is the borrow out
        diff = {1'b0, src} - {1'b0, working_q};
        adjusted  = working_q;
        adj_carry = carry_q;
        if (working_q[3:0] > ccd_pkg::DIGIT_MAX || half_q) begin
            adjusted = working_q + ccd_pkg::LOW_FIX;
        end
        if (working_q > ccd_pkg::PAIR_MAX || carry_q) begin
            adjusted  = adjusted + ccd_pkg::HIGH_FIX;
            adj_carry = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        working_d  = working_q;
        zero_d     = zero_q;
        carry_d    = carry_q;
        half_d     = half_q;
        expiry_d   = expiry_q;
        sleep_d    = sleep_q;
        file_we    = 1'b0;
        file_addr  = op_addr;
        file_wdata = ccd_pkg::ZERO_BYTE;
        result     = ccd_pkg::ZERO_BYTE;
        done_d     = op_valid;
        wdt_clr_d  = 1'b0;
        div_clr_d  = 1'b0;
        peek_d     = (32'(peek_addr) < FILE_DEPTH) ? file_q[peek_addr] : ccd_pkg::ZERO_BYTE;

        // Hardware events clear the active-low flags; a kick below wins
        if (watchdog_timeout_evt) begin
            expiry_d = 1'b0;
        end
        if (sleep_evt) begin
            sleep_d = 1'b0;
        end

        if (ext_we) begin
            file_we    = 1'b1;
            file_addr  = ext_addr;
            file_wdata = ext_wdata;
        end

        if (sum_load && !op_valid) begin
            working_d = sum_value;
            carry_d   = sum_carry;
            half_d    = sum_half_carry;
            zero_d    = (sum_value == ccd_pkg::ZERO_BYTE);
        end

        case (op)
            ccd_pkg::CCD_OP_ZERO_WORKING: begin
                working_d = ccd_pkg::ZERO_BYTE;
                zero_d    = 1'b1;
            end
            ccd_pkg::CCD_OP_ZERO_REGISTER: begin
                file_we    = 1'b1;
                file_addr  = op_addr;
                file_wdata = ccd_pkg::ZERO_BYTE;
                zero_d     = 1'b1;
            end
            ccd_pkg::CCD_OP_INVERT_REGISTER,
            ccd_pkg::CCD_OP_MINUS_ONE_REGISTER: begin
                if (op == ccd_pkg::CCD_OP_INVERT_REGISTER) begin
                    result = ~src;
                end else begin
                    result = src - ccd_pkg::ONE_BYTE;
                end
                zero_d = (result == ccd_pkg::ZERO_BYTE);
                if (op_dest == ccd_pkg::DEST_FILE) begin
                    file_we    = 1'b1;
                    file_addr  = op_addr;
                    file_wdata = result;
                end else begin
                    working_d = result;
                end
            end
            ccd_pkg::CCD_OP_WATCHDOG_KICK: begin
                wdt_clr_d = 1'b1;
                div_clr_d = divider_to_watchdog;
                expiry_d  = 1'b1;
                sleep_d   = 1'b1;
            end
            ccd_pkg::CCD_OP_COMPARE_WITH_REGISTER: begin
                // Difference is never stored anywhere
                zero_d  = (diff[DATA_W-1:0] == ccd_pkg::ZERO_BYTE);
                carry_d = ~diff[DATA_W];
            end
            ccd_pkg::CCD_OP_DECIMAL_ADJUST: begin
                // Relies on addition flags still standing from the previous cycle
                working_d = adjusted;
                carry_d   = adj_carry;
            end
            default: begin
            end
        endcase

        if (sys_rst) begin
            file_we = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            working_q <= ccd_pkg::WORKING_RST;
            zero_q    <= ccd_pkg::ZERO_FLAG_RST;
            carry_q   <= ccd_pkg::CARRY_FLAG_RST;
            half_q    <= ccd_pkg::HALF_FLAG_RST;
            expiry_q  <= ccd_pkg::EXPIRY_RST;
            sleep_q   <= ccd_pkg::SLEEP_RST;
            done_q    <= 1'b0;
            wdt_clr_q <= 1'b0;
            div_clr_q <= 1'b0;
            peek_q    <= ccd_pkg::ZERO_BYTE;
        end else begin
            working_q <= working_d;
            zero_q    <= zero_d;
            carry_q   <= carry_d;
            half_q    <= half_d;
            expiry_q  <= expiry_d;
            sleep_q   <= sleep_d;
            done_q    <= done_d;
            wdt_clr_q <= wdt_clr_d;
            div_clr_q <= div_clr_d;
            peek_q    <= peek_d;
        end
    end

    // File contents are data, not control, so reset leaves them alone
    always_ff @(posedge clk) begin
        if (file_we && 32'(file_addr) < FILE_DEPTH) begin
            file_q[file_addr] <= file_wdata;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign op_done                = done_q;
    assign peek_data              = peek_q;
    assign watchdog_counter_clear = wdt_clr_q;
    assign watchdog_divider_clear = div_clr_q;
    assign working_register       = working_q;
    assign result_null_flag       = zero_q;
    assign borrow_not_flag        = carry_q;
    assign half_carry_flag        = half_q;
    assign watchdog_expiry_flag   = expiry_q;
    assign sleep_entered_flag     = sleep_q;

endmodule

/* File: dv/ccd_checker.sv */
`timescale 1ns/100ps
module ccd_checker #(
    parameter int unsigned DATA_W = 8
) (
    // Clock, reset, issue
    input wire logic              clk,
    input wire logic              sys_rst,
    input wire logic              op_valid,
    input wire logic [2:0]        op_code,
    input wire logic              op_dest,
    input wire logic              divider_to_watchdog,
    // Observed state
    input wire logic              op_done,
    input wire logic              watchdog_counter_clear,
    input wire logic              watchdog_divider_clear,
    input wire logic [DATA_W-1:0] working_register,
    input wire logic              result_null_flag,
    input wire logic              borrow_not_flag,
    input wire logic              half_carry_flag,
    input wire logic              watchdog_expiry_flag,
    input wire logic              sleep_entered_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic kick;
    assign kick = op_valid && op_code == 3'h5;
    done_pulse_a: assert property (op_valid |=> op_done) else $error("done missing");
    done_idle_a: assert property (!op_valid |=> !op_done) else $error("stray done");
    zero_working_a: assert property (op_valid && op_code == 3'h1 |=> working_register == '0 && result_null_flag)
        else $error("zero working wrong");
    zero_reg_flag_a: assert property (op_valid && op_code == 3'h2 |=> result_null_flag && $stable(working_register))
        else $error("zero register wrong");
    to_working_a: assert property (op_valid && op_code inside {3'h3, 3'h4} && !op_dest
        |=> result_null_flag == (working_register == '0)) else $error("zero flag wrong");
    minus_flags_a: assert property (op_valid && op_code == 3'h4 |=> $stable(borrow_not_flag))
        else $error("decrement touched carry");
    kick_flags_a: assert property (kick |=> watchdog_expiry_flag && sleep_entered_flag
        && $stable(result_null_flag) && $stable(borrow_not_flag)) else $error("kick flags wrong");
    divider_clear_a: assert property (kick |=> watchdog_counter_clear
        && watchdog_divider_clear == $past(divider_to_watchdog)) else $error("kick clears wrong");
    no_clear_a: assert property (!kick |=> !watchdog_counter_clear && !watchdog_divider_clear)
        else $error("stray clear");
    compare_keep_a: assert property (op_valid && op_code == 3'h6 |=> $stable(working_register))
        else $error("compare changed working");
    adjust_flags_a: assert property (op_valid && op_code == 3'h7
        |=> $stable(result_null_flag) && $stable(half_carry_flag)) else $error("adjust touched flags");
    cover property (kick && divider_to_watchdog);
    cover property (op_valid && op_code == 3'h7);
    cover property (op_valid && op_code == 3'h6);
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    // ------------------------------------------------------------
    // Design ports and reference state
    // ------------------------------------------------------------
    logic       clk = 1'b0, sys_rst = 1'b1, op_valid = 1'b0, op_dest = 1'b0, sum_load = 1'b0;
    logic       sum_carry = 1'b0, sum_half_carry = 1'b0, ext_we = 1'b0, divider_to_watchdog = 1'b0;
    logic       watchdog_timeout_evt = 1'b0, sleep_evt = 1'b0, op_done, watchdog_counter_clear;
    logic       watchdog_divider_clear, result_null_flag, borrow_not_flag, half_carry_flag;
    logic       watchdog_expiry_flag, sleep_entered_flag, z, c, h, xf, sf;
    logic [2:0] op_code = 3'h0;
    logic [5:0] op_addr = 6'h00, ext_addr = 6'h00, peek_addr = 6'h00;
    logic [7:0] sum_value = 8'h00, ext_wdata = 8'h00, working_register, peek_data, w, r;
    logic [7:0] fm [64];
    int         n_mismatch = 0, total_checks = 0, cycles = 0;
    always #5 clk = ~clk;
    ccd_datapath ccd_datapath_inst (.clk, .sys_rst, .op_valid, .op_code, .op_addr, .op_dest, .op_done,
        .sum_load, .sum_value, .sum_carry, .sum_half_carry, .ext_we, .ext_addr, .ext_wdata, .peek_addr,
        .peek_data, .divider_to_watchdog, .watchdog_timeout_evt, .sleep_evt, .watchdog_counter_clear,
        .watchdog_divider_clear, .working_register, .result_null_flag, .borrow_not_flag,
        .half_carry_flag, .watchdog_expiry_flag, .sleep_entered_flag);
    // ------------------------------------------------------------
    // Checking and expectations
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    function automatic logic [8:0] daa(input logic [7:0] v, input logic cy, input logic hc);
        logic [7:0] t;
        t = (v[3:0] > 4'h9 || hc) ? v + 8'h06 : v;
        return (v > 8'h99 || cy) ? {1'b1, t + 8'h60} : {cy, t};
    endfunction
    function automatic logic [8:0] bcd_sum(input logic [7:0] a, input logic [7:0] b);
        int n;
        n = a[7:4] * 10 + a[3:0] + b[7:4] * 10 + b[3:0];
        return {n >= 100, 4'((n % 100) / 10), 4'(n % 10)};
    endfunction
    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        @(posedge clk);
        ext_we    <= 1'b1;
        ext_addr  <= a;
        ext_wdata <= v;
        @(posedge clk);
        ext_we <= 1'b0;
        fm[a] = v;
    endtask
    task automatic evt(input logic t, input logic s);
        @(posedge clk);
        watchdog_timeout_evt <= t;
        sleep_evt            <= s;
        @(posedge clk);
        watchdog_timeout_evt <= 1'b0;
        sleep_evt            <= 1'b0;
        xf = xf & !t;
        sf = sf & !s;
    endtask
    task automatic issue(input logic [2:0] k, input logic [5:0] a, input logic d);
        @(posedge clk);
        op_valid            <= 1'b1;
        op_code             <= k;
        op_addr             <= a;
        op_dest             <= d;
        divider_to_watchdog <= 1'($urandom);
        @(posedge clk);
        op_valid  <= 1'b0;
        peek_addr <= a;
        r = (k == 3'h3) ? ~fm[a] : (k == 3'h4) ? fm[a] - 8'h01 : 8'h00;
        if (k >= 3'h1 && k <= 3'h4) z = (r == 8'h00);
        if (k == 3'h6) z = (fm[a] == w);
        if (k == 3'h6) c = (fm[a] >= w);
        if (k == 3'h7) {c, w} = daa(w, c, h);
        if (k == 3'h5) {xf, sf} = 2'b11;
        if (k == 3'h1 || (k inside {3'h3, 3'h4} && !d)) w = r;
        if (k == 3'h2 || (k inside {3'h3, 3'h4} && d)) fm[a] = r;
        #1;
        chk(8'(op_done), 8'h01);
        chk(working_register, w);
        chk(8'({result_null_flag, borrow_not_flag, half_carry_flag}), 8'({z, c, h}));
        chk(8'({watchdog_expiry_flag, sleep_entered_flag}), 8'({xf, sf}));
        chk(8'({watchdog_counter_clear, watchdog_divider_clear}), 8'({k == 3'h5, k == 3'h5 && divider_to_watchdog}));
        @(posedge clk);
        #1;
        chk(peek_data, fm[a]);
    endtask
    task automatic add_daa(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = a + b;
        @(posedge clk);
        sum_load       <= 1'b1;
        sum_value      <= s[7:0];
        sum_carry      <= s[8];
        sum_half_carry <= (a[3:0] + b[3:0]) > 5'h0f;
        @(posedge clk);
        sum_load <= 1'b0;
        {c, h, w} = {s[8], (a[3:0] + b[3:0]) > 5'h0f, s[7:0]};
        z = (s[7:0] == 8'h00);
        issue(3'h7, 6'($urandom), 1'($urandom));
        chk(working_register, 8'(bcd_sum(a, b)));
        chk(8'(borrow_not_flag), 8'(bcd_sum(a, b) >> 8));
    endtask
    task automatic rst_pulse();
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        {w, z, c, h, xf, sf} = {8'h00, 5'b00011};
        #1;
        chk(working_register, w);
        chk(8'({result_null_flag, borrow_not_flag, half_carry_flag}), 8'({z, c, h}));
        chk(8'({watchdog_expiry_flag, sleep_entered_flag}), 8'({xf, sf}));
        chk(8'({op_done, watchdog_counter_clear, watchdog_divider_clear}), 8'h00);
        chk(peek_data, 8'h00);
    endtask
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        void'($urandom(6));
        {w, z, c, h, xf, sf} = {8'h00, 5'b00011};
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 64; i++) wr(6'(i), 8'($urandom));
        wr(6'h05, 8'h01);
        issue(3'h4, 6'h05, 1'b1);
        issue(3'h3, 6'h3f, 1'b0);
        wr(6'h3f, 8'h00);
        issue(3'h1, 6'h00, 1'b1);
        issue(3'h6, 6'h3f, 1'b0);
        issue(3'h2, 6'h00, 1'b0);
        evt(1'b1, 1'b1);
        issue(3'h5, 6'h00, 1'b0);
        add_daa(8'h28, 8'h25);
        add_daa(8'h99, 8'h99);
        // Mid-run reset after flags and carries have moved off their reset values
        evt(1'b1, 1'b1);
        rst_pulse();
        repeat (300) begin
            if ($urandom_range(7) == 0) evt(1'($urandom), 1'($urandom));
            if ($urandom_range(3) == 0) add_daa({4'($urandom_range(9)), 4'($urandom_range(9))},
                {4'($urandom_range(9)), 4'($urandom_range(9))});
            else issue(3'($urandom), 6'($urandom), 1'($urandom));
        end
        results();
    end
endmodule
bind ccd_datapath ccd_checker #(.DATA_W(DATA_W)) ccd_checker_inst (.clk, .sys_rst, .op_valid, .op_code,
    .op_dest, .divider_to_watchdog, .op_done, .watchdog_counter_clear, .watchdog_divider_clear,
    .working_register, .result_null_flag, .borrow_not_flag, .half_carry_flag, .watchdog_expiry_flag,
    .sleep_entered_flag);
